// ---- rtl/mbrs_pkg.sv ----
// Package: constants, types and helpers of the Modbus RTU slave handler.
package mbrs_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BAUD_TBL [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  // Silence of 3.5 characters of 11 bits, 38.5 bit times rounded up.
  localparam int unsigned GAP_BITS = 39;
  localparam logic [3:0] STOP_BIT = 4'h9;
  // ----------------------------------------------------------------
  // Protocol codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  localparam logic [7:0] BCAST = 8'h00;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WR1 = 8'h06;
  localparam logic [7:0] FN_WRN = 8'h10;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_NOWR = 8'h04;
  localparam logic [7:0] EXC_OVER = 8'ha0;
  localparam logic [7:0] EXC_UNDER = 8'h60;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  // ----------------------------------------------------------------
  // Register map and ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_MEAS = 16'h0001;
  localparam logic [15:0] REG_STAT = 16'h0002;
  localparam logic [15:0] REG_DP = 16'h0003;
  localparam logic [15:0] REG_ADDR = 16'h0020;
  localparam logic [15:0] REG_ID = 16'h0021;
  localparam logic [15:0] REG_BAUD = 16'h0022;
  localparam logic [15:0] REG_PERM = 16'h0024;
  localparam logic [15:0] REG_AMODE = 16'h00a0;
  localparam logic [15:0] DP_MAX = 16'h0003;
  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'h00f7;
  localparam logic [15:0] BAUD_MAX = 16'h0007;
  localparam logic [15:0] PERM_MAX = 16'h0001;
  localparam logic [15:0] AMODE_MAX = 16'h0005;
  localparam logic [15:0] READ_MAX = 16'h0010;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] BUF_LEN = 6'd41;
  localparam logic [5:0] POS_ADDR = 6'd0;
  localparam logic [5:0] POS_FN = 6'd1;
  localparam logic [5:0] POS_REG_H = 6'd2;
  localparam logic [5:0] POS_REG_L = 6'd3;
  localparam logic [5:0] POS_CNT_H = 6'd4;
  localparam logic [5:0] POS_CNT_L = 6'd5;
  localparam logic [5:0] POS_BC = 6'd6;
  localparam logic [5:0] POS_WDATA = 6'd7;
  localparam logic [5:0] POS_RBC = 6'd2;
  localparam logic [5:0] POS_RDATA = 6'd3;
  localparam logic [5:0] POS_EXC = 6'd2;
  localparam logic [5:0] LEN_MIN = 6'd4;
  localparam logic [5:0] LEN_FIX = 6'd8;
  localparam logic [7:0] LEN_WRN_FIX = 8'd9;
  localparam logic [5:0] LEN_EXC = 6'd3;
  localparam logic [5:0] LEN_WR_RSP = 6'd6;
  localparam logic [5:0] LEN_CRC = 6'd2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_RECV, ST_CHECK, ST_EXEC, ST_EXC, ST_REPLY, ST_TX, ST_DONE} mbrs_state_e;
  typedef struct packed {
    logic [7:0] node_addr;
    logic [2:0] baud;
    logic [1:0] dp;
    logic perm;
    logic [2:0] amode;
  } mbrs_cfg_s;
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] status;
    logic over;
    logic under;
  } mbrs_meas_s;
  typedef struct packed {
    logic frame_taken;
    logic frame_dropped;
    logic exception;
    logic reg_written;
  } mbrs_evt_s;
  localparam mbrs_cfg_s CFG_RST = '{node_addr: 8'h01, baud: 3'h3, dp: 2'h0, perm: 1'b1, amode: 3'h0};

  function automatic logic [15:0] mbrs_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mbrs_crc_byte

  function automatic logic [15:0] mbrs_bit_div(input logic [2:0] code);
    return 16'(CLK_HZ / BAUD_TBL[code]);
  endfunction : mbrs_bit_div
endpackage : mbrs_pkg

// ---- rtl/mbrs_rx.sv ----
// Serial character receiver with pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
module mbrs_rx import mbrs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Line and bit timing
  input wire logic rx_pin_i,
  input wire logic [15:0] div_i,
  // Received character and synchronised line level
  output logic [7:0] data_o,
  output logic valid_o,
  output logic line_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic busy;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] data;
    logic valid;
  } mbrs_rx_s;
  mbrs_rx_s st, next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = rx_pin_i;
    next_st.s2 = st.s1;
    next_st.valid = 1'b0;
    if (!st.busy) begin
      if (!st.s2) begin
        next_st.busy = 1'b1;
        next_st.cnt = {1'b0, div_i[15:1]};
        next_st.bitn = '0;
      end
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 16'h0001;
    end else begin
      next_st.cnt = div_i - 16'h0001;
      if (st.bitn == '0 && st.s2) begin
        // A start bit that is high again at mid-bit is a glitch.
        next_st.busy = 1'b0;
      end else if (st.bitn == STOP_BIT) begin
        next_st.busy = 1'b0;
        next_st.valid = st.s2;
        next_st.data = st.sh;
      end else begin
        if (st.bitn != '0) begin
          next_st.sh = {st.s2, st.sh[7:1]};
        end
        next_st.bitn = st.bitn + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.s1 <= 1'b1;
      st.s2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign data_o = st.data;
  assign valid_o = st.valid;
  assign line_o = st.s2;
endmodule : mbrs_rx
`default_nettype wire

// ---- rtl/mbrs_tx.sv ----
// Serial character transmitter, one start and one stop bit.
`timescale 1ns/1ps
`default_nettype none
module mbrs_tx import mbrs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Character request
  input wire logic start_i,
  input wire logic [7:0] data_i,
  input wire logic [15:0] div_i,
  output logic ready_o,
  // Line
  output logic tx_o
);
  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic tx;
  } mbrs_tx_s;
  mbrs_tx_s st, next_st;

  always_comb begin
    next_st = st;
    if (!st.busy) begin
      if (start_i) begin
        next_st.busy = 1'b1;
        next_st.cnt = div_i - 16'h0001;
        next_st.bitn = '0;
        next_st.sh = {1'b1, data_i};
        next_st.tx = 1'b0;
      end
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 16'h0001;
    end else if (st.bitn == STOP_BIT) begin
      next_st.busy = 1'b0;
    end else begin
      next_st.cnt = div_i - 16'h0001;
      next_st.tx = st.sh[0];
      next_st.sh = {1'b1, st.sh[8:1]};
      next_st.bitn = st.bitn + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.tx <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign ready_o = !st.busy;
  assign tx_o = st.tx;
endmodule : mbrs_tx
`default_nettype wire

// ---- rtl/mbrs_handler.sv ----
// Modbus RTU slave handler: framing, decode, register file and reply.
`timescale 1ns/1ps
`default_nettype none
module mbrs_handler import mbrs_pkg::*; #(
  // Arbitrary value naming the device type.
  parameter logic [15:0] ID_CODE = 16'h5a3c
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // RS-485 line
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  output logic tx_drive_o,
  // Meter side
  input wire mbrs_meas_s meas_i,
  input wire logic analog_fitted_i,
  input wire logic menu_unblock_i,
  output var mbrs_cfg_s cfg_o,
  output var mbrs_evt_s evt_o
);
  typedef struct packed {
    mbrs_state_e state;
    logic [5:0] len;
    logic [5:0] idx;
    logic [15:0] crc;
    logic [23:0] gap;
    logic ovf;
    logic bcast;
    logic [7:0] fn;
    logic [15:0] start;
    logic [15:0] count;
    logic [4:0] k;
    logic commit;
    logic [7:0] exc;
    logic [7:0] pend_addr;
    logic pend;
    logic drive;
    mbrs_cfg_s cfg;
    mbrs_evt_s evt;
  } mbrs_main_s;
  mbrs_main_s st, next_st;
  logic [7:0] frame_buf [0:BUF_LEN-1];

  logic [15:0] bit_div;
  logic [23:0] gap_lim;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_line;
  logic tx_ready;
  logic tx_start;
  logic [7:0] tx_byte;
  logic wa_en;
  logic wb_en;
  logic [5:0] wa_idx;
  logic [5:0] wb_idx;
  logic [7:0] wa_dat;
  logic [7:0] wb_dat;
  logic [15:0] reg_a;
  logic [15:0] wr_val;
  logic [15:0] rd_val;
  logic [15:0] req_cnt;
  logic [7:0] rd_code;
  logic [7:0] wr_code;
  logic [7:0] req_fn;
  logic [5:0] wd_idx;
  logic [5:0] rd_idx;
  logic frame_ok;
  logic fn_ok;
  logic len_ok;
  logic cnt_ok;

  // ----------------------------------------------------------------
  // Line side
  // ----------------------------------------------------------------
  // The divisor follows the live baud setting, so a reply right after
  // a baud write already goes out at the new rate.
  assign bit_div = mbrs_bit_div(st.cfg.baud);
  assign gap_lim = 24'(bit_div) * 24'(GAP_BITS);

  mbrs_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .rx_pin_i(rx_pin_i),
    .div_i(bit_div),
    .data_o(rx_data),
    .valid_o(rx_valid),
    .line_o(rx_line)
  );

  mbrs_tx u_tx (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .start_i(tx_start),
    .data_i(tx_byte),
    .div_i(bit_div),
    .ready_o(tx_ready),
    .tx_o(tx_pin_o)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign req_fn = frame_buf[POS_FN];
  assign req_cnt = {frame_buf[POS_CNT_H], frame_buf[POS_CNT_L]};
  assign frame_ok = !st.ovf && st.len >= LEN_MIN && st.crc == CRC_GOOD
    && (frame_buf[POS_ADDR] == st.cfg.node_addr || frame_buf[POS_ADDR] == BCAST);
  assign fn_ok = req_fn == FN_READ || req_fn == FN_WR1 || req_fn == FN_WRN;
  assign cnt_ok = req_fn == FN_WR1 || (req_cnt != '0 && req_cnt <= READ_MAX);
  assign len_ok = (req_fn == FN_WRN)
    ? ({2'b00, st.len} == 8'(LEN_WRN_FIX + frame_buf[POS_BC])
       && frame_buf[POS_BC] == {req_cnt[6:0], 1'b0})
    : st.len == LEN_FIX;
  assign reg_a = st.start + 16'(st.k);
  assign wd_idx = POS_WDATA + {st.k, 1'b0};
  assign rd_idx = POS_RDATA + {st.k, 1'b0};
  assign wr_val = (st.fn == FN_WR1) ? {frame_buf[POS_CNT_H], frame_buf[POS_CNT_L]}
    : {frame_buf[wd_idx], frame_buf[6'(wd_idx + 6'h01)]};

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 16'h0000;
    rd_code = EXC_NONE;
    case (reg_a)
      REG_MEAS: begin
        rd_val = meas_i.value;
        if (st.count == 16'h0001) begin
          if (meas_i.over) begin
            rd_code = EXC_OVER;
          end else if (meas_i.under) begin
            rd_code = EXC_UNDER;
          end
        end
      end
      REG_STAT: rd_val = meas_i.status;
      REG_DP: rd_val = 16'(st.cfg.dp);
      REG_ADDR: rd_val = 16'(st.cfg.node_addr);
      REG_ID: rd_val = ID_CODE;
      REG_BAUD: rd_val = 16'(st.cfg.baud);
      REG_PERM: rd_val = 16'(st.cfg.perm);
      REG_AMODE: begin
        if (analog_fitted_i) begin
          rd_val = 16'(st.cfg.amode);
        end else begin
          rd_code = EXC_ADDR;
        end
      end
      default: rd_code = EXC_ADDR;
    endcase
  end

  // Read-only and unmapped registers both answer as illegal address.
  always_comb begin
    wr_code = EXC_NONE;
    case (reg_a)
      REG_DP: begin
        if (wr_val > DP_MAX) wr_code = EXC_DATA;
      end
      REG_ADDR: begin
        if (wr_val > ADDR_MAX || wr_val < ADDR_MIN) wr_code = EXC_DATA;
      end
      REG_BAUD: begin
        if (wr_val > BAUD_MAX) wr_code = EXC_DATA;
      end
      REG_PERM: begin
        if (wr_val > PERM_MAX) wr_code = EXC_DATA;
      end
      REG_AMODE: begin
        if (!analog_fitted_i) begin
          wr_code = EXC_ADDR;
        end else if (wr_val > AMODE_MAX) begin
          wr_code = EXC_DATA;
        end
      end
      default: wr_code = EXC_ADDR;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.evt = '0;
    wa_en = 1'b0;
    wa_idx = st.len;
    wa_dat = rx_data;
    wb_en = 1'b0;
    wb_idx = rd_idx + 6'h01;
    wb_dat = rd_val[7:0];
    tx_start = 1'b0;
    if (st.idx < st.len) begin
      tx_byte = frame_buf[st.idx];
    end else if (st.idx == st.len) begin
      tx_byte = st.crc[7:0];
    end else begin
      tx_byte = st.crc[15:8];
    end
    if (menu_unblock_i) begin
      next_st.cfg.perm = 1'b1;
    end
    case (st.state)
      ST_RECV: begin
        if (!rx_line) begin
          next_st.gap = '0;
        end else if (st.gap < gap_lim) begin
          next_st.gap = st.gap + 24'h000001;
        end
        if (rx_valid) begin
          if (st.len < BUF_LEN) begin
            wa_en = 1'b1;
            next_st.len = st.len + 6'h01;
            next_st.crc = mbrs_crc_byte(st.crc, rx_data);
          end else begin
            next_st.ovf = 1'b1;
          end
        end else if (rx_line && st.gap >= gap_lim && st.len != '0) begin
          next_st.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_st.fn = req_fn;
        next_st.bcast = frame_buf[POS_ADDR] == BCAST;
        next_st.start = {frame_buf[POS_REG_H], frame_buf[POS_REG_L]};
        next_st.count = (req_fn == FN_WR1) ? 16'h0001 : req_cnt;
        next_st.k = '0;
        next_st.commit = 1'b0;
        next_st.state = ST_EXC;
        if (!frame_ok) begin
          next_st.evt.frame_dropped = 1'b1;
          next_st.state = ST_DONE;
        end else if (!fn_ok) begin
          next_st.exc = EXC_FUNC;
        end else if (!len_ok || !cnt_ok) begin
          next_st.exc = EXC_DATA;
        end else if (req_fn != FN_READ && !st.cfg.perm) begin
          next_st.exc = EXC_NOWR;
        end else begin
          next_st.evt.frame_taken = 1'b1;
          next_st.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (st.fn == FN_READ) begin
          if (16'(st.k) == st.count) begin
            wa_en = 1'b1;
            wa_idx = POS_RBC;
            wa_dat = {st.count[6:0], 1'b0};
            next_st.len = POS_RDATA + {st.count[4:0], 1'b0};
            next_st.state = ST_REPLY;
          end else if (rd_code != EXC_NONE) begin
            next_st.exc = rd_code;
            next_st.state = ST_EXC;
          end else begin
            wa_en = 1'b1;
            wa_idx = rd_idx;
            wa_dat = rd_val[15:8];
            wb_en = 1'b1;
            next_st.k = st.k + 5'h01;
          end
        end else if (16'(st.k) == st.count) begin
          // First pass only checks, so a rejected multiple write changes nothing.
          next_st.k = '0;
          next_st.commit = 1'b1;
          if (st.commit) begin
            next_st.len = LEN_WR_RSP;
            next_st.state = ST_REPLY;
          end
        end else if (!st.commit && wr_code != EXC_NONE) begin
          next_st.exc = wr_code;
          next_st.state = ST_EXC;
        end else begin
          next_st.k = st.k + 5'h01;
          if (st.commit) begin
            next_st.evt.reg_written = 1'b1;
            case (reg_a)
              REG_DP: next_st.cfg.dp = wr_val[1:0];
              REG_ADDR: begin
                next_st.pend_addr = wr_val[7:0];
                next_st.pend = 1'b1;
              end
              REG_BAUD: next_st.cfg.baud = wr_val[2:0];
              REG_PERM: next_st.cfg.perm = next_st.cfg.perm & wr_val[0];
              REG_AMODE: next_st.cfg.amode = wr_val[2:0];
              default: next_st.evt.reg_written = 1'b0;
            endcase
          end
        end
      end
      ST_EXC: begin
        wa_en = 1'b1;
        wa_idx = POS_FN;
        wa_dat = st.fn | EXC_FLAG;
        wb_en = 1'b1;
        wb_idx = POS_EXC;
        wb_dat = st.exc;
        next_st.len = LEN_EXC;
        next_st.evt.exception = 1'b1;
        next_st.state = ST_REPLY;
      end
      ST_REPLY: begin
        next_st.idx = '0;
        next_st.crc = CRC_INIT;
        if (st.bcast) begin
          next_st.state = ST_DONE;
        end else begin
          next_st.drive = 1'b1;
          next_st.state = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_ready) begin
          if (st.idx == st.len + LEN_CRC) begin
            next_st.state = ST_DONE;
          end else begin
            tx_start = 1'b1;
            next_st.idx = st.idx + 6'h01;
            if (st.idx < st.len) begin
              next_st.crc = mbrs_crc_byte(st.crc, tx_byte);
            end
          end
        end
      end
      ST_DONE: begin
        // The new address takes over only once the reply has left.
        if (st.pend) begin
          next_st.cfg.node_addr = st.pend_addr;
          next_st.pend = 1'b0;
        end
        next_st.drive = 1'b0;
        next_st.len = '0;
        next_st.ovf = 1'b0;
        next_st.gap = '0;
        next_st.crc = CRC_INIT;
        next_st.state = ST_RECV;
      end
      default: next_st.state = ST_DONE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.crc <= CRC_INIT;
      st.cfg <= CFG_RST;
    end else begin
      st <= next_st;
    end
  end

  // Frame memory carries no reset; every byte sent in a reply is written before it is read.
  always_ff @(posedge clk_sys_i) begin
    if (wa_en) begin
      frame_buf[wa_idx] <= wa_dat;
    end
    if (wb_en) begin
      frame_buf[wb_idx] <= wb_dat;
    end
  end

  assign tx_drive_o = st.drive;
  assign cfg_o = st.cfg;
  assign evt_o = st.evt;
endmodule : mbrs_handler
`default_nettype wire

// ---- test/mbrs_handler_props.sv ----
// Checker of the line and configuration outputs of the slave handler.
`timescale 1ns/1ps
`default_nettype none
module mbrs_handler_props import mbrs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Watched ports
  input wire logic tx_pin_o,
  input wire logic tx_drive_o,
  input wire logic analog_fitted_i,
  input wire logic menu_unblock_i,
  input wire mbrs_cfg_s cfg_o,
  input wire mbrs_evt_s evt_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_line_idle: assert property (!tx_drive_o |-> tx_pin_o)
    else $error("line low while not driven");
  a_start_first: assert property ($rose(tx_drive_o) |-> tx_pin_o ##1 !tx_pin_o)
    else $error("reply does not open with a start bit");
  a_stop_last: assert property ($past(reset_n_i) && $fell(tx_drive_o) |-> $past(tx_pin_o, 2))
    else $error("driver released before stop bit");
  a_drop_quiet: assert property (evt_o.frame_dropped |=> !tx_drive_o [*8])
    else $error("reply after dropped frame");
  a_drop_excl: assert property (!(evt_o.frame_taken && evt_o.frame_dropped))
    else $error("frame both taken and dropped");
  a_addr_late: assert property ($past(reset_n_i) && $changed(cfg_o.node_addr)
    |-> !tx_drive_o && $past(tx_pin_o))
    else $error("address changed during reply");
  a_addr_range: assert property (cfg_o.node_addr >= 8'h01 && cfg_o.node_addr <= 8'hf7)
    else $error("address out of range");
  a_no_unblock: assert property ($past(reset_n_i) && $rose(cfg_o.perm) |-> $past(menu_unblock_i))
    else $error("writes unblocked without menu");
  a_amode_fit: assert property ($past(reset_n_i) && $changed(cfg_o.amode)
    |-> analog_fitted_i && cfg_o.amode <= 3'h5)
    else $error("analogue mode changed while absent");
  c_reply: cover property ($rose(tx_drive_o));
  c_drop: cover property (evt_o.frame_dropped);
  c_exc: cover property (evt_o.exception);
  c_write: cover property (evt_o.reg_written);
endmodule : mbrs_handler_props
bind mbrs_handler mbrs_handler_props u_props (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .tx_pin_o(tx_pin_o), .tx_drive_o(tx_drive_o), .analog_fitted_i(analog_fitted_i),
  .menu_unblock_i(menu_unblock_i), .cfg_o(cfg_o), .evt_o(evt_o));
`default_nettype wire

// ---- test/mbrs_master.sv ----
// Bus master model: sends request frames and collects the reply characters.
`timescale 1ns/1ps
`default_nettype none
module mbrs_master (
  // Clock
  input wire logic clk_sys_i,
  // Line
  output logic line_o,
  input wire logic tx_i,
  input wire logic drive_i
);
  int bit_clks = 4167;
  logic [7:0] rsp [$];
  initial line_o = 1'b1;
  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [7:0] q [$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) for (int b = 0; b < 10; b++) begin
      @(posedge clk_sys_i) line_o <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : q[i][b-1];
      repeat (bit_clks - 1) @(posedge clk_sys_i);
    end
  endtask : send
  task automatic recv(input int lim);
    logic [7:0] b;
    int n;
    rsp.delete();
    n = 0;
    while (!drive_i && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
    while (drive_i) begin
      @(posedge clk_sys_i);
      if (!tx_i) begin
        repeat (bit_clks / 2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
          repeat (bit_clks) @(posedge clk_sys_i);
          b[i] = tx_i;
        end
        repeat (bit_clks) @(posedge clk_sys_i);
        rsp.push_back(b);
      end
    end
    // Idle long enough that the next request is framed apart from this one.
    repeat (8 * bit_clks) @(posedge clk_sys_i);
  endtask : recv
endmodule : mbrs_master
`default_nettype wire

// ---- test/mbrs_handler_tb.sv ----
// Self-checking bench of the slave handler against the master model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module mbrs_handler_tb import mbrs_pkg::*;;
  localparam int FAST = CLK_HZ / BAUD_TBL[7];
  logic clk_sys;
  logic reset_n;
  logic rx_line;
  logic tx_line;
  logic tx_drive;
  logic fitted;
  logic unblock;
  mbrs_meas_s meas;
  mbrs_cfg_s cfg;
  mbrs_evt_s evt;
  int fail_count = 0;
  int comparisons = 0;
  mbrs_handler #(.ID_CODE(16'h5a3c)) DUT (.clk_sys_i(clk_sys), .reset_n_i(reset_n),
    .rx_pin_i(rx_line), .tx_pin_o(tx_line), .tx_drive_o(tx_drive), .meas_i(meas),
    .analog_fitted_i(fitted), .menu_unblock_i(unblock), .cfg_o(cfg), .evt_o(evt));
  mbrs_master m (.clk_sys_i(clk_sys), .line_o(rx_line), .tx_i(tx_line), .drive_i(tx_drive));
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // The reply is heard at the fast rate, which also covers the baud change itself.
  task automatic xfer(input logic [79:0] req, input int nr, input logic [87:0] exp,
    input int ne, input logic bad = 1'b0);
    logic [7:0] q [$];
    logic [7:0] e [$];
    logic [15:0] c;
    int lim;
    for (int i = 0; i < nr; i++) q.push_back(req[8*(nr-1-i) +: 8]);
    for (int i = 0; i < ne; i++) e.push_back(exp[8*(ne-1-i) +: 8]);
    c = m.crc16(e);
    if (ne > 0) e = {e, c[7:0], c[15:8]};
    m.send(q, bad);
    // The silence that ends a request is timed at the rate the request was sent at.
    lim = 60 * m.bit_clks;
    m.bit_clks = FAST;
    m.recv(lim);
    `CHK(m.rsp.size(), e.size())
    foreach (e[i]) `CHK(m.rsp[i], e[i])
  endtask : xfer
  task automatic t_baud();
    xfer(48'h010600220007, 6, 48'h010600220007, 6);
    `CHK(cfg.baud, 3'h7)
  endtask : t_baud
  task automatic t_read();
    xfer(48'h010300010003, 6, 72'h010306000a00000000, 9);
    xfer(48'h010300210001, 6, 40'h0103025a3c, 5);
  endtask : t_read
  task automatic t_range();
    @(posedge clk_sys) meas.under <= 1'b1;
    xfer(48'h010300010001, 6, 24'h018360, 3);
    @(posedge clk_sys) meas.over <= 1'b1;
    xfer(48'h010300010001, 6, 24'h0183a0, 3);
    xfer(48'h010300010002, 6, 56'h010304000a0000, 7);
    @(posedge clk_sys) meas <= '{16'h000a, 16'h0000, 1'b0, 1'b0};
  endtask : t_range
  task automatic t_codes();
    xfer(48'h010400010001, 6, 24'h018401, 3);
    xfer(48'h010300100001, 6, 24'h018302, 3);
    xfer(48'h010600030004, 6, 24'h018603, 3);
    xfer(48'h010300010011, 6, 24'h018303, 3);
    xfer(72'h011000030001020002, 9, 48'h011000030001, 6);
    `CHK(cfg.dp, 2'h2)
  endtask : t_codes
  task automatic t_crc();
    xfer(48'h010300010001, 6, 0, 0, 1'b1);
    xfer(48'h050300010001, 6, 0, 0);
  endtask : t_crc
  task automatic t_analog();
    xfer(48'h010600a00002, 6, 24'h018602, 3);
    @(posedge clk_sys) fitted <= 1'b1;
    xfer(48'h000600a00002, 6, 0, 0);
    `CHK(cfg.amode, 3'h2)
  endtask : t_analog
  task automatic t_perm();
    xfer(48'h010600240000, 6, 48'h010600240000, 6);
    xfer(48'h010600030001, 6, 24'h018604, 3);
    `CHK(cfg.dp, 2'h2)
    xfer(48'h010600240001, 6, 24'h018604, 3);
    `CHK(cfg.perm, 1'b0)
    @(posedge clk_sys) unblock <= 1'b1;
    @(posedge clk_sys) unblock <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(cfg.perm, 1'b1)
  endtask : t_perm
  task automatic t_addr();
    xfer(48'h010600200002, 6, 48'h010600200002, 6);
    `CHK(cfg.node_addr, 8'h02)
    xfer(48'h020300030001, 6, 40'h0203020002, 5);
  endtask : t_addr
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100_000_000;
    fail_count++;
    complete_run();
  end
  initial begin
    reset_n = 1'b0;
    fitted = 1'b0;
    unblock = 1'b0;
    meas = '{16'h000a, 16'h0000, 1'b0, 1'b0};
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_baud();
    t_read();
    t_range();
    t_codes();
    t_crc();
    t_analog();
    t_perm();
    t_addr();
    complete_run();
  end
endmodule : mbrs_handler_tb
`default_nettype wire
